// File: hdl/pin_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes: First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	if (W < 1) begin : g_bad_width
		$error("pin_sync width must be at least one");
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign pin_sync_out = sync_q;

endmodule : pin_sync

`default_nettype wire

// File: hdl/result_shifter.sv
// Purpose: Shifts a conversion result out MSB first, then trailing zeros
// Assumes: shift is a one-cycle pulse per serial clock falling edge
// Notes: done marks the falling edge that carries the last bit
`timescale 1ns/1ps
`default_nettype none
`include "touch_adc_map.svh"

module result_shifter #(
	parameter int W = `TA_BITS_12
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic load,
	input wire logic eight_bit,
	input wire logic [W-1:0] data,
	input wire logic shift,
	input wire logic abort,
	output logic dout,
	output logic done
);

	logic [W-1:0] sh_q, sh_d;
	logic [3:0] left_q, left_d;
	logic dout_q, dout_d;

	if (W <= `TA_BITS_8 || W > 15) begin : g_bad_width
		$error("result_shifter width must be 9 to 15");
	end

	always_comb begin
		sh_d = sh_q;
		left_d = left_q;
		dout_d = dout_q;
		if (abort) begin
			left_d = 4'h0;
			dout_d = 1'b0;
		end else if (load) begin
			sh_d = data;
			left_d = eight_bit ? 4'(`TA_BITS_8) : 4'(W);
		end else if (shift) begin
			if (left_q != 4'h0) begin
				dout_d = sh_q[W-1];
				sh_d = {sh_q[W-2:0], 1'b0};
				left_d = left_q - 4'h1;
			end else begin
				dout_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sh_q <= '0;
			left_q <= 4'h0;
			dout_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			left_q <= left_d;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;
	assign done = shift && !abort && !load && left_q == 4'h1;

endmodule : result_shifter

`default_nettype wire

// File: hdl/touch_adc_serial_control.sv
// Purpose: Serial control word, sequencing, power and plate control of a touch ADC
// Assumes: Pins are asynchronous; conv_data is presented by the converter core
// Notes: Serial clock is sampled by clk_sys and must be well below half its rate
//
// How it works
// - A high serial bit opens a control word; earlier low bits are ignored.
// - A new word starts no sooner than 15 clocks, or 11 in 8-bit mode.
// - Channel bits with reference bit steer multiplexer, plate switches and reference.
// - Resolution bit picks 12-bit when 0, 8-bit when 1.
// - Ratiometric conversions keep plate switches on until conversion end.
// - Mode 00: reference off, converter sleeps after conversion or select release.
// - Mode 01: reference off, converter always on, touch interrupt enabled.
// - Mode 10: reference on, converter sleeps between conversions.
// - Mode 11: everything on, touch interrupt disabled.
// - Differential work in modes 00 or 01 never wakes the reference.
// - Converter wakes on fourth falling edge, sleeps on the final one.
// - Select low enables busy and serial output drivers and starts a transfer.
// - Eight clocks carry the word; each bit updates the register on arrival.
// - Three acquisition clocks, then power bits latch, hold, busy rises.
// - Busy drops on the next falling serial clock edge.
// - Single-ended conversions switch the plates off at hold.
// - Twelve clocks shift the result; host adds clocks for zeros.
// - Channel 001 drives the Y plates, 101 the X plates.
// - Modes 00, 01, 10 turn the negative Y switch on after conversion.
// - Mode 11 keeps drivers on until setup changes or select rises.
// - 8-bit conversions end four clocks earlier.
// - Reference bit 1 means single-ended, 0 means ratiometric.
// - Power bits reset to 10.
// - Lead bit disarms touch interrupt; output releases on fourth falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "touch_adc_map.svh"

module touch_adc_serial_control
	import touch_adc_pkg::*;
#(
	parameter int CONV_BITS = `TA_BITS_12
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic conversion_shift_clock,
	input wire logic serial_in,
	input wire logic touch_sense,
	input wire logic [CONV_BITS-1:0] conv_data,
	output logic serial_out,
	output logic serial_out_oe,
	output logic busy,
	output logic busy_oe,
	output logic touch_irq_n_out,
	output logic touch_irq_n_oe,
	output logic [2:0] mux_sel,
	output logic ref_single_ended,
	output logic ref_on,
	output logic adc_on,
	output logic y_drv_on,
	output logic x_drv_on,
	output logic yneg_on,
	output logic sample_hold
);

	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	logic [3:0] pins_s;
	logic cs_s, sclk_s, serial_in_s, touch_s;
	logic sclk_prev_q;
	logic rise_e, fall_e;

	pin_sync #(.W(4)) u_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in({cs_n, conversion_shift_clock, serial_in, touch_sense}),
		.pin_sync_out(pins_s)
	);

	assign {cs_s, sclk_s, serial_in_s, touch_s} = pins_s;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	assign rise_e = !cs_s && sclk_s && !sclk_prev_q;
	assign fall_e = !cs_s && !sclk_s && sclk_prev_q;

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	seq_state_t state_q, state_d;
	logic [2:0] bit_cnt_q, bit_cnt_d;
	logic [4:0] fe_cnt_q, fe_cnt_d;
	logic [4:0] rise_cnt_q, rise_cnt_d;
	logic [7:0] ctrl_q, ctrl_d;
	pd_mode_t pd_q, pd_d;
	logic eight_q, eight_d;
	logic busy_q, busy_d;
	logic adc_up_q, adc_up_d;
	logic irq_armed_q, irq_armed_d;
	logic irq_low_q, irq_low_d;
	logic plates_q, plates_d;
	logic [4:0] cfg_q, cfg_d;
	logic yneg_idle_q, yneg_idle_d;
	logic hold_q, hold_d;
	logic [4:0] gap;
	logic start_e, hold_e, load_e, eoc;
	logic [2:0] ctrl_idx;

	if (CONV_BITS <= `TA_BITS_8 || CONV_BITS > 15) begin : g_bad_bits
		$error("CONV_BITS must be 9 to 15");
	end

	// spacing depends on the running resolution
	assign gap = eight_q ? `TA_GAP_8 : `TA_GAP_12;
	// first high bit opens a word
	assign start_e = rise_e && serial_in_s && (state_q == ST_IDLE ||
		(state_q == ST_CONV && rise_cnt_q >= gap - 5'h01));
	assign hold_e = rise_e && state_q == ST_WORD && bit_cnt_q == `TA_LAST_BIT;
	assign load_e = fall_e && state_q == ST_CONV && fe_cnt_q == `TA_LOAD_FALL - 5'h01;
	assign ctrl_idx = 3'(`TA_CHAN_HI) - bit_cnt_q;

	always_comb begin
		state_d = state_q;
		bit_cnt_d = bit_cnt_q;
		fe_cnt_d = fe_cnt_q;
		rise_cnt_d = rise_cnt_q;
		ctrl_d = ctrl_q;
		pd_d = pd_q;
		eight_d = eight_q;
		busy_d = busy_q;
		adc_up_d = adc_up_q;
		irq_armed_d = irq_armed_q;
		irq_low_d = irq_low_q;
		plates_d = plates_q;
		cfg_d = cfg_q;
		yneg_idle_d = yneg_idle_q;
		hold_d = 1'b0;
		if (cs_s) begin
			// select release ends the frame and sleeps the converter unless the low power bit is set
			state_d = ST_IDLE;
			busy_d = 1'b0;
			adc_up_d = 1'b0;
			// drivers drop when select is high
			plates_d = 1'b0;
		end else begin
			if (fall_e && state_q != ST_IDLE) begin
				if (fe_cnt_q != 5'h1F) begin
					fe_cnt_d = fe_cnt_q + 5'h01;
				end
				// busy lasts to the next falling edge
				busy_d = 1'b0;
				if (fe_cnt_q == `TA_WAKE_FALL - 5'h01) begin
					adc_up_d = 1'b1;
					irq_low_d = 1'b0;
				end
			end
			if (rise_e && rise_cnt_q != 5'h1F) begin
				rise_cnt_d = rise_cnt_q + 5'h01;
			end
			if (start_e) begin
				state_d = ST_WORD;
				bit_cnt_d = 3'h0;
				fe_cnt_d = 5'h00;
				rise_cnt_d = 5'h00;
				ctrl_d[`TA_START_BIT] = 1'b1;
				// lead bit disarms the touch interrupt
				irq_armed_d = 1'b0;
				yneg_idle_d = 1'b0;
			end else if (rise_e && state_q == ST_WORD) begin
				ctrl_d[ctrl_idx] = serial_in_s;
				bit_cnt_d = bit_cnt_q + 3'h1;
				if (bit_cnt_q == `TA_CHAN_KNOWN) begin
					plates_d = 1'b1;
				end
				if (hold_e) begin
					// power bits latch, hold and busy
					pd_d = pd_mode_t'({ctrl_q[`TA_PD_HI], serial_in_s});
					eight_d = ctrl_q[`TA_MODE_BIT];
					busy_d = 1'b1;
					hold_d = 1'b1;
					cfg_d = ctrl_q[`TA_CHAN_HI:`TA_REF_BIT];
					state_d = ST_CONV;
					if (ctrl_q[`TA_REF_BIT]) begin
						plates_d = 1'b0;
					end
				end
			end
			if (state_q == ST_WORD && bit_cnt_q < `TA_CHAN_KNOWN && plates_q && pd_q == PD_FULL &&
				ctrl_q[`TA_CHAN_HI:`TA_REF_BIT] != cfg_q) begin
				plates_d = 1'b0;
			end
			if (eoc) begin
				if (state_q != ST_WORD) begin
					adc_up_d = 1'b0;
					// interrupt only rearmed below full power
					irq_armed_d = pd_q != PD_FULL;
				end
				if (state_q == ST_CONV) begin
					state_d = ST_IDLE;
				end
				if (pd_q != PD_FULL) begin
					plates_d = 1'b0;
					yneg_idle_d = 1'b1;
				end
			end
		end
		if (irq_armed_d) begin
			irq_low_d = touch_s;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			bit_cnt_q <= 3'h0;
			fe_cnt_q <= 5'h00;
			rise_cnt_q <= 5'h00;
			ctrl_q <= `TA_CTRL_RESET;
			pd_q <= pd_mode_t'(`TA_PD_RESET);
			eight_q <= 1'b0;
			busy_q <= 1'b0;
			adc_up_q <= 1'b0;
			irq_armed_q <= 1'b1;
			irq_low_q <= 1'b0;
			plates_q <= 1'b0;
			cfg_q <= 5'h00;
			yneg_idle_q <= 1'b1;
			hold_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_cnt_q <= bit_cnt_d;
			fe_cnt_q <= fe_cnt_d;
			rise_cnt_q <= rise_cnt_d;
			ctrl_q <= ctrl_d;
			pd_q <= pd_d;
			eight_q <= eight_d;
			busy_q <= busy_d;
			adc_up_q <= adc_up_d;
			irq_armed_q <= irq_armed_d;
			irq_low_q <= irq_low_d;
			plates_q <= plates_d;
			cfg_q <= cfg_d;
			yneg_idle_q <= yneg_idle_d;
			hold_q <= hold_d;
		end
	end

	// ----------------------------------------
	// Result shifter
	// ----------------------------------------
	// result leaves over the falling edges after hold
	result_shifter #(.W(CONV_BITS)) u_shift (
		.clk_sys(clk_sys),
		.rst(rst),
		.load(load_e),
		.eight_bit(eight_q),
		.data(conv_data),
		.shift(fall_e),
		.abort(cs_s),
		.dout(serial_out),
		.done(eoc)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// drivers live while select is low
	assign serial_out_oe = !cs_s;
	assign busy_oe = !cs_s;
	assign busy = busy_q;
	assign touch_irq_n_out = 1'b0;
	assign touch_irq_n_oe = irq_low_q;
	assign mux_sel = ctrl_q[`TA_CHAN_HI:`TA_CHAN_LO];
	assign ref_single_ended = ctrl_q[`TA_REF_BIT];
	// reference follows the high power bit only
	assign ref_on = pd_q[`TA_PD_HI];
	assign adc_on = pd_q[`TA_PD_LO] || adc_up_q;
	assign y_drv_on = plates_q && mux_sel == `TA_CH_YDRV;
	assign x_drv_on = plates_q && mux_sel == `TA_CH_XDRV;
	assign yneg_on = y_drv_on || yneg_idle_q;
	assign sample_hold = hold_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_hold;
		hold_e && !cs_s;
	endsequence

	sequence s_busy_pulse;
		busy_q ##0 sample_hold;
	endsequence

	sequence s_wake_edge;
		fall_e && state_q != ST_IDLE && fe_cnt_q == 5'h03;
	endsequence

	a_hold_busy: assert property (s_hold |=> s_busy_pulse ##0 pd_q[0] == $past(serial_in_s))
		else $error("busy or power bits wrong at hold");
	a_busy_drop: assert property (busy_q && fall_e |=> !busy_q)
		else $error("busy outlived a falling edge");
	a_pins_live: assert property (serial_out_oe == !cs_s && busy_oe == !cs_s)
		else $error("output enables do not follow select");
	a_adc_wake: assert property (s_wake_edge |=> adc_on && !touch_irq_n_oe)
		else $error("converter not awake on fourth falling edge");
	a_adc_sleep: assert property (eoc && state_q == ST_CONV && pd_q == PD_AUTO |=> !adc_on)
		else $error("converter still on after conversion");
	a_full_power: assert property (pd_q == PD_FULL && state_q == ST_IDLE |-> adc_on && ref_on && !irq_armed_q)
		else $error("full power mode wrong");
	a_irq_disarm: assert property (start_e |=> !irq_armed_q && state_q == ST_WORD)
		else $error("lead bit did not disarm touch interrupt");
	a_yneg_idle: assert property (eoc && pd_q != PD_FULL |=> yneg_on [*2])
		else $error("negative Y not on after conversion");
	a_start_gap: assert property (start_e && state_q == ST_CONV |-> rise_cnt_q >= gap - 5'h01)
		else $error("word started too soon");
	a_plate_pick: assert property (plates_q && mux_sel == 3'h1 |-> y_drv_on && !x_drv_on)
		else $error("wrong plate pair driven");

endmodule : touch_adc_serial_control

`default_nettype wire

// File: include/touch_adc_map.svh
// Purpose: Offsets, field positions, reset values and counts of the touch ADC control
// Assumes: Included by bare name; definitions only
// Notes: Counts are serial clock edges from the lead-marker bit
`ifndef TOUCH_ADC_MAP_SVH
`define TOUCH_ADC_MAP_SVH

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define TA_START_BIT 7
`define TA_CHAN_HI 6
`define TA_CHAN_LO 4
`define TA_MODE_BIT 3
`define TA_REF_BIT 2
`define TA_PD_HI 1
`define TA_PD_LO 0
`define TA_CTRL_RESET 8'h02
`define TA_PD_RESET 2'h2
`define TA_CH_YDRV 3'h1
`define TA_CH_XDRV 3'h5

// ----------------------------------------
// Sequencing counts
// ----------------------------------------
`define TA_CHAN_KNOWN 3'h2
`define TA_LAST_BIT 3'h6
`define TA_WAKE_FALL 5'h04
`define TA_LOAD_FALL 5'h08
`define TA_GAP_12 5'h0F
`define TA_GAP_8 5'h0B
`define TA_BITS_12 12
`define TA_BITS_8 8

`endif

// File: include/touch_adc_pkg.sv
// Purpose: Types shared by the touch ADC control files
// Assumes: Nothing
// Notes: Binary codes written out
package touch_adc_pkg;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WORD = 2'b01,
		ST_CONV = 2'b10
	} seq_state_t;

	typedef enum logic [1:0] {
		PD_AUTO = 2'b00,
		PD_ADC_ON = 2'b01,
		PD_REF_ON = 2'b10,
		PD_FULL = 2'b11
	} pd_mode_t;

endpackage : touch_adc_pkg

// File: verification/host_serial_model.sv
// Purpose: Host serial port model driving the touch ADC control link
// Assumes: Changes its lines just after the falling clk_sys edge
// Notes: Serial clock idles low outside frames; rx_sr keeps the last 64 sampled bits
`timescale 1ns/1ps
`default_nettype none

module host_serial_model (
	input wire logic clk_sys,
	input wire logic serial_out,
	output logic cs_n,
	output logic sclk,
	output logic serial_in
);
	logic [63:0] rx_sr;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
		rx_sr = '0;
	end

	// ----------------------------------------
	// Link cycles
	// ----------------------------------------
	// one bit per clock
	task automatic sclk_cycle(input logic b);
		serial_in = b;
		repeat (4) @(negedge clk_sys);
		sclk = 1'b1;
		repeat (4) @(negedge clk_sys);
		rx_sr = {rx_sr[62:0], serial_out};
		sclk = 1'b0;
	endtask : sclk_cycle

	// eight bits from the lead bit, then trailing clocks
	task automatic frame(input logic [7:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			sclk_cycle(i < 8 ? w[7 - i] : 1'b0);
		end
	endtask : frame

	task automatic select();
		cs_n = 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask : select

	task automatic deselect();
		serial_in = 1'b0;
		cs_n = 1'b1;
		repeat (8) @(negedge clk_sys);
	endtask : deselect
endmodule : host_serial_model

`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench for the touch ADC serial control
// Assumes: Host model drives the link; bench drives touch and converter inputs
// Notes: Result bits are read back from the host shift register
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic clk_sys, rst, touch_sense, cs_n, sclk, serial_in, serial_out;
	logic serial_out_oe, busy, busy_oe, irq_oe, ref_se, ref_on, adc_on;
	logic y_drv, x_drv, yneg, sh;
	logic [2:0] mux_sel;
	logic [11:0] conv_data;
	int errors = 0;
	int tests_run = 0;
	int busy_n = 0;
	int sh_n = 0;

	touch_adc_serial_control touch_adc_serial_control_i (
		.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .conversion_shift_clock(sclk),
		.serial_in(serial_in), .touch_sense(touch_sense), .conv_data(conv_data),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe), .busy(busy),
		.busy_oe(busy_oe), .touch_irq_n_out(), .touch_irq_n_oe(irq_oe),
		.mux_sel(mux_sel), .ref_single_ended(ref_se), .ref_on(ref_on),
		.adc_on(adc_on), .y_drv_on(y_drv), .x_drv_on(x_drv), .yneg_on(yneg),
		.sample_hold(sh)
	);

	host_serial_model host_serial_model_i (
		.clk_sys(clk_sys), .serial_out(serial_out), .cs_n(cs_n), .sclk(sclk),
		.serial_in(serial_in)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge busy) busy_n++;
	always @(posedge sh) sh_n++;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic at_fall(input int n);
		repeat (n) @(negedge sclk);
		repeat (6) @(negedge clk_sys);
	endtask : at_fall

	task automatic run_overlap(input logic [7:0] w, input int n);
		int b0;
		int s0;
		int bits;
		logic [11:0] m;
		logic [11:0] e;
		b0 = busy_n;
		s0 = sh_n;
		bits = w[3] ? 8 : 12;
		m = w[3] ? 12'h0FF : 12'hFFF;
		e = w[3] ? {4'h0, conv_data[11:4]} : conv_data;
		host_serial_model_i.select();
		host_serial_model_i.frame(w, n);
		host_serial_model_i.frame(w ^ 8'h20, n);
		host_serial_model_i.frame(8'h00, n);
		for (int k = 0; k < 2; k++) begin
			chk("ovl_res", e, 12'(host_serial_model_i.rx_sr >> (3*n - k*n - 9 - bits)) & m);
		end
		chk("ovl_mux", 3'h3, mux_sel); // second word
		chk("busy_cnt", 12'h002, 12'(busy_n - b0));
		chk("hold_cnt", 12'h002, 12'(sh_n - s0));
		host_serial_model_i.deselect();
	endtask : run_overlap

	task automatic print_verdict();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [7:0] w;
		rst = 1'b1;
		touch_sense = 1'b0;
		conv_data = 12'hA5C;
		repeat (20) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk("ref_on", 1'b1, ref_on); // reset value
		chk("adc_on", 1'b0, adc_on); // reset value
		host_serial_model_i.select();
		chk("sout_oe", 1'b1, serial_out_oe); // enabled
		chk("busy_oe", 1'b1, busy_oe); // enabled
		host_serial_model_i.frame(8'h00, 3); // low bits ignored
		host_serial_model_i.frame(8'hB6, 24); // word in
		chk("mux_sel", 3'h3, mux_sel); // channel
		chk("ref_se", 1'b1, ref_se); // single-ended
		chk("result", conv_data, host_serial_model_i.rx_sr[14:3]); // result
		chk("trail", 3'h0, host_serial_model_i.rx_sr[2:0]); // zeros
		host_serial_model_i.frame(8'hBE, 24); // 8-bit word
		chk("result8", conv_data[11:4], host_serial_model_i.rx_sr[14:7]); // result
		chk("trail8", 7'h00, host_serial_model_i.rx_sr[6:0]); // early end
		host_serial_model_i.deselect();
		chk("sout_oe", 1'b0, serial_out_oe); // released
		touch_sense = 1'b1;
		conv_data = 12'h3C9;
		for (int p = 0; p < 4; p++) begin
			w = {5'h12, 1'b0, p[1:0]};
			host_serial_model_i.select();
			fork
				host_serial_model_i.frame(w, 24);
				begin
					at_fall(4);
					chk("adc_up", 1'b1, adc_on); // wake
					chk("irq_off", 1'b0, irq_oe); // released
					at_fall(16);
					chk("adc_eoc", p[0], adc_on); // sleep
				end
			join
			chk("ref_on", p[1], ref_on); // reference
			chk("irq_arm", p != 3, irq_oe); // interrupt
			chk("yneg", 1'b1, yneg); // idle switch, or held Y drivers in mode 11
			if (p == 3) chk("y_drv", 1'b1, y_drv); // held
			host_serial_model_i.deselect();
			chk("y_drv_cs", 1'b0, y_drv); // dropped
		end
		host_serial_model_i.select();
		host_serial_model_i.frame(8'hD3, 24);
		chk("x_drv", 1'b1, x_drv); // X plates
		chk("y_drv", 1'b0, y_drv); // Y idle
		host_serial_model_i.deselect();
		run_overlap(8'h95, 15); // fifteen clocks
		run_overlap(8'h95, 16); // sixteen clocks
		run_overlap(8'h9D, 11); // eleven clocks
		print_verdict();
	end

	initial begin
		#200000;
		errors++;
		$display("[ERR] watchdog expected done seen hang");
		print_verdict();
	end
endmodule : tb

`default_nettype wire
